// *** pkg/port_power_defines.vh ***
// Purpose: Shared constants for the downstream port power manager
// Assumes: 50 MHz core clock, 16-bit register port with 4-bit address
// Notes:   Offsets are word indexes on the plain register port
`ifndef PORT_POWER_DEFINES_VH
`define PORT_POWER_DEFINES_VH

// Clock and over-current filter timing
`define CLK_PERIOD_NS      20
`define OC_FILTER_NS       8000
`define OC_FILTER_CYCLES   ((`OC_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Register offsets
`define REG_POWER_CTRL     4'h0
`define REG_SPLIT_CTRL     4'h1
`define REG_CHARGE_CTRL    4'h2
`define REG_FILTER_LEN     4'h3
`define REG_OC_STATUS      4'h4
`define REG_CC_CFG         4'h5
`define REG_CC_STATUS      4'h6
`define REG_CC_EVENTS      4'h7

// Reset values
`define RST_POWER_CTRL     16'h0000
`define RST_SPLIT_CTRL     4'h0
`define RST_CHARGE_CTRL    4'h0
`define RST_CC_CFG         8'h09

// Field positions inside one port's CC configuration byte
`define CC_CFG_ROLE_DFP    0
`define CC_CFG_ADV_LSB     1
`define CC_CFG_ADV_MSB     2
`define CC_CFG_VCONN_AUTO  3
`define CC_CFG_THR_LSB     4
`define CC_CFG_THR_MSB     6

// Current advertisement codes
`define ADV_3A0            2'b00
`define ADV_1A5            2'b01
`define ADV_DEFAULT        2'b10
`define ADV_OFF            2'b11

`endif

// *** rtl/oc_filter.v ***
// Purpose: Glitch filter for one active-low over-current sense input
// Assumes: low_i already synchronised to clk_i
// Notes:   One trip pulse per continuous low episode
module oc_filter (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Sense
  input  wire        arm_i,
  input  wire        low_i,
  input  wire [15:0] len_i,
  output reg         trip_o
);

  reg [15:0] count;
  reg        done;

  // Count consecutive low cycles while armed, trip once at length
  always @(posedge clk_i)
  begin
    if (!rst_n_i || !arm_i || !low_i)
    begin
      count  <= 16'h0000;
      done   <= 1'b0;
      trip_o <= 1'b0;
    end
    else if (!done)
    begin
      if (count >= len_i)
      begin
        trip_o <= 1'b1;
        done   <= 1'b1;
      end
      else
      begin
        count <= count + 16'h0001;
      end
    end
    else
    begin
      trip_o <= 1'b0;
    end
  end

endmodule

// *** rtl/cc_port_ctrl.v ***
// Purpose: CC attach, advertisement and plug supply control of one port
// Assumes: All inputs synchronised; comparator gives a 3-bit level index
// Notes:   Plug supply sits on the CC pin opposite the pull-down
module cc_port_ctrl (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Configuration
  input  wire        role_dfp_i,
  input  wire [1:0]  adv_sel_i,
  input  wire        vconn_auto_i,
  input  wire [2:0]  thresh_i,
  input  wire [15:0] filt_len_i,
  input  wire        ocp_clr_i,
  // Comparator results
  input  wire [2:0]  cc_a_level_i,
  input  wire [2:0]  cc_b_level_i,
  input  wire        cc_a_ra_i,
  input  wire        cc_b_ra_i,
  input  wire        vconn_low_a_i,
  input  wire        vconn_low_b_i,
  input  wire        vbus_safe5v_i,
  input  wire        vbus_safe0v_i,
  // Control and status
  output reg         attached_o,
  output reg         flip_o,
  output reg  [1:0]  adv_code_o,
  output reg         rd_en_o,
  output reg         vconn_a_o,
  output reg         vconn_b_o,
  output reg         ocp_o,
  output reg  [2:0]  partner_level_o,
  output reg         level_chg_o
);

`include "port_power_defines.vh"

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SRC  = 3'b010;
  localparam [2:0] ST_SNK  = 3'b100;

  reg  [2:0] state;
  reg        ocp_off;
  wire       ocp_trip;
  wire       rd_a      = (cc_a_level_i >= thresh_i);
  wire       rd_b      = (cc_b_level_i >= thresh_i);
  wire       cable_ra  = flip_o ? cc_a_ra_i : cc_b_ra_i;
  wire       vconn_low = flip_o ? vconn_low_a_i : vconn_low_b_i;
  wire [2:0] level_max = (cc_a_level_i > cc_b_level_i) ? cc_a_level_i : cc_b_level_i;
  wire       vconn_ok  = vconn_auto_i & cable_ra & ~ocp_off & ~ocp_trip;

  // Plug supply over-current filter on the active pin
  oc_filter u_ocp (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .arm_i   (vconn_a_o | vconn_b_o),
    .low_i   (vconn_low),
    .len_i   (filt_len_i),
    .trip_o  (ocp_trip)
  );

  // Attach state machine and plug supply selection
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state           <= ST_IDLE;
      attached_o      <= 1'b0;
      flip_o          <= 1'b0;
      adv_code_o      <= `ADV_OFF;
      rd_en_o         <= 1'b0;
      vconn_a_o       <= 1'b0;
      vconn_b_o       <= 1'b0;
      ocp_o           <= 1'b0;
      ocp_off         <= 1'b0;
      partner_level_o <= 3'h0;
      level_chg_o     <= 1'b0;
    end
    else
    begin
      ocp_o       <= ocp_trip;
      level_chg_o <= 1'b0;
      // Shut-off latch, trip wins over clear
      if (ocp_trip)
        ocp_off <= 1'b1;
      else if (ocp_clr_i)
        ocp_off <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          attached_o <= 1'b0;
          vconn_a_o  <= 1'b0;
          vconn_b_o  <= 1'b0;
          rd_en_o    <= ~role_dfp_i;
          adv_code_o <= role_dfp_i ? adv_sel_i : `ADV_OFF;
          if (role_dfp_i && (rd_a || rd_b))
          begin
            state      <= ST_SRC;
            attached_o <= 1'b1;
            flip_o     <= ~rd_a;
          end
          else if (!role_dfp_i && vbus_safe5v_i)
          begin
            state      <= ST_SNK;
            attached_o <= 1'b1;
          end
        end
        ST_SRC:
        begin
          adv_code_o <= adv_sel_i;
          if (!role_dfp_i || !(rd_a || rd_b))
          begin
            state     <= ST_IDLE;
            vconn_a_o <= 1'b0;
            vconn_b_o <= 1'b0;
            ocp_off   <= 1'b0;
          end
          else
          begin
            vconn_a_o <= vconn_ok & flip_o;
            vconn_b_o <= vconn_ok & ~flip_o;
          end
        end
        ST_SNK:
        begin
          if (role_dfp_i || vbus_safe0v_i)
          begin
            state <= ST_IDLE;
          end
          else if (level_max != partner_level_o)
          begin
            partner_level_o <= level_max;
            level_chg_o     <= 1'b1;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** rtl/port_power_manager.v ***
// Purpose: Downstream port power, over-current and CC control of a hub
// Assumes: Four downstream ports, ports 1 and 2 reversible, 50 MHz clock
// Notes:   Pins are open-drain; pin level is resolved outside this block
//
// What this block does
// - One shared power enable and over-current sense pin per downstream port.
// - Power off drives the shared pin actively low.
// - Pull-up is off while the pin is driven low.
// - Power on releases the driver and enables the pull-up: open drain.
// - While powered, a low on the pin means over-current.
// - Short lows, such as at power-up, are filtered out.
// - Fuse arrangement uses the same pin behaviour and low detection.
// - Without split, the primary pin governs both port halves.
// - With split, second pin governs the superspeed half only.
// - Every port starts in non-split mode after reset.
// - Charging supply indication is set per port.
// - Eight programmable attach thresholds judge the CC voltage.
// - Source role advertises 3A by default, lowerable to 1.5A or default.
// - Sink role presents pull-downs and waits for bus voltage.
// - Sink role notices changes in advertised current level.
// - Source role enables plug supply when an active cable is seen.
// - Plug supply is on at most one CC pin.
// - Plug supply pin is chosen only once attach is detected.
// - Plug supply pin below 3.0V is over-current and turns the FET off.
// - Sink attach and detach follow the bus voltage range comparator.
//
// Implementation choices: the register offsets and strobed register access.
module port_power_manager (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Register port
  input  wire [3:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  // Shared power and sense pins, primary half
  input  wire [3:0]  port_power_sense_pin_i,
  output reg  [3:0]  port_power_sense_pin_o,
  output reg  [3:0]  port_power_sense_pin_oe_o,
  output reg  [3:0]  port_power_sense_pullup_o,
  // Shared power and sense pins, superspeed half
  input  wire [3:0]  superspeed_power_sense_pin_i,
  output reg  [3:0]  superspeed_power_sense_pin_o,
  output reg  [3:0]  superspeed_power_sense_pin_oe_o,
  output reg  [3:0]  superspeed_power_sense_pullup_o,
  // Charging supply indication
  output reg  [3:0]  charge_supply_present_o,
  // CC comparators of ports 1 and 2
  input  wire [11:0] cc_level_i,
  input  wire [3:0]  cc_ra_i,
  input  wire [3:0]  vconn_low_i,
  input  wire [3:0]  bus_voltage_monitor_i,
  // CC controls of ports 1 and 2
  output wire [3:0]  cc_adv_code_o,
  output wire [1:0]  cc_rd_enable_o,
  output reg  [5:0]  cc_threshold_o,
  output wire        port1_plug_supply_enable_a_o,
  output wire        port1_plug_supply_enable_b_o,
  output reg         port2_plug_supply_enable_o
);

`include "port_power_defines.vh"

  localparam [15:0] FILT_RST = `OC_FILTER_CYCLES;

  // Registers
  reg  [15:0] power_ctrl;
  reg  [3:0]  split_ctrl;
  reg  [15:0] filter_len;
  reg  [3:0]  oc_prim;
  reg  [3:0]  oc_ss;
  reg  [1:0]  oc_plug;
  reg  [1:0]  lvl_evt;
  reg  [15:0] cc_cfg;

  // Synchroniser for all asynchronous inputs
  reg  [31:0] sync_a;
  reg  [31:0] sync_b;

  wire [3:0]  prim_in  = sync_b[3:0];
  wire [3:0]  ss_in    = sync_b[7:4];
  wire [11:0] cc_lvl   = sync_b[19:8];
  wire [3:0]  cc_ra    = sync_b[23:20];
  wire [3:0]  vc_low   = sync_b[27:24];
  wire [3:0]  bus_voltage_monitor = sync_b[31:28];

  // Effective enables per half
  wire [3:0]  prim_en = power_ctrl[3:0];
  wire [3:0]  ss_en   = split_ctrl & power_ctrl[7:4];
  wire [3:0]  prim_trip;
  wire [3:0]  ss_trip;
  wire [3:0]  ss_event;
  wire [1:0]  plug_trip;
  wire [1:0]  lvl_chg;
  wire [1:0]  attached;
  wire [1:0]  flip;
  wire [8:0]  p1_level;
  wire [8:0]  p2_level;
  wire        p2_vc_a;
  wire        p2_vc_b;

  // Write decode and clear strobes
  wire        wr_oc  = reg_wr_i && (reg_addr_i == `REG_OC_STATUS);
  wire        wr_evt = reg_wr_i && (reg_addr_i == `REG_CC_EVENTS);
  wire [1:0]  plug_clr = wr_oc ? reg_wdata_i[9:8] : 2'b00;

  // Two-flop capture of pins and comparators
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= 32'h00000000;
      sync_b <= 32'h00000000;
    end
    else
    begin
      sync_a <= {bus_voltage_monitor_i, vconn_low_i, cc_ra_i, cc_level_i,
                 superspeed_power_sense_pin_i, port_power_sense_pin_i};
      sync_b <= sync_a;
    end
  end

  // Over-current filters, one per half of each port
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_filt
      oc_filter u_prim (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .arm_i   (prim_en[gi] & port_power_sense_pullup_o[gi]),
        .low_i   (~prim_in[gi]),
        .len_i   (filter_len),
        .trip_o  (prim_trip[gi])
      );
      oc_filter u_ss (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .arm_i   (ss_en[gi] & superspeed_power_sense_pullup_o[gi]),
        .low_i   (~ss_in[gi]),
        .len_i   (filter_len),
        .trip_o  (ss_trip[gi])
      );
      // Superspeed half follows primary pin unless split
      assign ss_event[gi] = split_ctrl[gi] ? ss_trip[gi] : prim_trip[gi];
    end
  endgenerate

  // Pin drivers: low with pull-up off, or released with pull-up on; superspeed pins of non-split ports released with pull-up off
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      port_power_sense_pin_o          <= 4'h0;
      port_power_sense_pin_oe_o       <= 4'hf;
      port_power_sense_pullup_o       <= 4'h0;
      superspeed_power_sense_pin_o    <= 4'h0;
      superspeed_power_sense_pin_oe_o <= 4'h0;
      superspeed_power_sense_pullup_o <= 4'h0;
    end
    else
    begin
      port_power_sense_pin_o          <= 4'h0;
      port_power_sense_pin_oe_o       <= ~prim_en;
      port_power_sense_pullup_o       <= prim_en;
      superspeed_power_sense_pin_o    <= 4'h0;
      // Second pin only in use for split ports
      superspeed_power_sense_pin_oe_o <= split_ctrl & ~ss_en;
      superspeed_power_sense_pullup_o <= ss_en;
    end
  end

  // Reversible port 1
  cc_port_ctrl u_cc1 (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .role_dfp_i      (cc_cfg[`CC_CFG_ROLE_DFP]),
    .adv_sel_i       (cc_cfg[`CC_CFG_ADV_MSB:`CC_CFG_ADV_LSB]),
    .vconn_auto_i    (cc_cfg[`CC_CFG_VCONN_AUTO]),
    .thresh_i        (cc_cfg[`CC_CFG_THR_MSB:`CC_CFG_THR_LSB]),
    .filt_len_i      (filter_len),
    .ocp_clr_i       (plug_clr[0]),
    .cc_a_level_i    (cc_lvl[2:0]),
    .cc_b_level_i    (cc_lvl[5:3]),
    .cc_a_ra_i       (cc_ra[0]),
    .cc_b_ra_i       (cc_ra[1]),
    .vconn_low_a_i   (vc_low[0]),
    .vconn_low_b_i   (vc_low[1]),
    .vbus_safe5v_i   (bus_voltage_monitor[0]),
    .vbus_safe0v_i   (bus_voltage_monitor[1]),
    .attached_o      (attached[0]),
    .flip_o          (flip[0]),
    .adv_code_o      (cc_adv_code_o[1:0]),
    .rd_en_o         (cc_rd_enable_o[0]),
    .vconn_a_o       (port1_plug_supply_enable_a_o),
    .vconn_b_o       (port1_plug_supply_enable_b_o),
    .ocp_o           (plug_trip[0]),
    .partner_level_o (p1_level[2:0]),
    .level_chg_o     (lvl_chg[0])
  );

  // Reversible port 2
  cc_port_ctrl u_cc2 (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .role_dfp_i      (cc_cfg[8 + `CC_CFG_ROLE_DFP]),
    .adv_sel_i       (cc_cfg[8 + `CC_CFG_ADV_MSB:8 + `CC_CFG_ADV_LSB]),
    .vconn_auto_i    (cc_cfg[8 + `CC_CFG_VCONN_AUTO]),
    .thresh_i        (cc_cfg[8 + `CC_CFG_THR_MSB:8 + `CC_CFG_THR_LSB]),
    .filt_len_i      (filter_len),
    .ocp_clr_i       (plug_clr[1]),
    .cc_a_level_i    (cc_lvl[8:6]),
    .cc_b_level_i    (cc_lvl[11:9]),
    .cc_a_ra_i       (cc_ra[2]),
    .cc_b_ra_i       (cc_ra[3]),
    .vconn_low_a_i   (vc_low[2]),
    .vconn_low_b_i   (vc_low[3]),
    .vbus_safe5v_i   (bus_voltage_monitor[2]),
    .vbus_safe0v_i   (bus_voltage_monitor[3]),
    .attached_o      (attached[1]),
    .flip_o          (flip[1]),
    .adv_code_o      (cc_adv_code_o[3:2]),
    .rd_en_o         (cc_rd_enable_o[1]),
    .vconn_a_o       (p2_vc_a),
    .vconn_b_o       (p2_vc_b),
    .ocp_o           (plug_trip[1]),
    .partner_level_o (p2_level[2:0]),
    .level_chg_o     (lvl_chg[1])
  );

  assign p1_level[8:3] = 6'h00;
  assign p2_level[8:3] = 6'h00;

  // Port 2 has one plug supply enable; only one side is ever on
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      port2_plug_supply_enable_o <= 1'b0;
    else
      port2_plug_supply_enable_o <= p2_vc_a | p2_vc_b;
  end

  // Configuration registers
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      power_ctrl              <= `RST_POWER_CTRL;
      split_ctrl              <= `RST_SPLIT_CTRL;
      charge_supply_present_o <= `RST_CHARGE_CTRL;
      filter_len              <= FILT_RST;
      cc_cfg                  <= {`RST_CC_CFG, `RST_CC_CFG};
      cc_threshold_o          <= 6'h00;
    end
    else
    begin
      cc_threshold_o <= {cc_cfg[8 + `CC_CFG_THR_MSB:8 + `CC_CFG_THR_LSB],
                         cc_cfg[`CC_CFG_THR_MSB:`CC_CFG_THR_LSB]};
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          `REG_POWER_CTRL:  power_ctrl <= {8'h00, reg_wdata_i[7:0]};
          `REG_SPLIT_CTRL:  split_ctrl <= reg_wdata_i[3:0];
          `REG_CHARGE_CTRL: charge_supply_present_o <= reg_wdata_i[3:0];
          `REG_FILTER_LEN:  filter_len <= reg_wdata_i;
          `REG_CC_CFG:      cc_cfg <= {1'b0, reg_wdata_i[14:8], 1'b0, reg_wdata_i[6:0]};
          default:          power_ctrl <= power_ctrl;
        endcase
      end
    end
  end

  // Sticky event flags, write one to clear, set wins over clear
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      oc_prim <= 4'h0;
      oc_ss   <= 4'h0;
      oc_plug <= 2'b00;
      lvl_evt <= 2'b00;
    end
    else
    begin
      oc_prim <= (oc_prim & ~(wr_oc ? reg_wdata_i[3:0] : 4'h0)) | prim_trip;
      oc_ss   <= (oc_ss & ~(wr_oc ? reg_wdata_i[7:4] : 4'h0)) | ss_event;
      oc_plug <= (oc_plug & ~plug_clr) | plug_trip;
      lvl_evt <= (lvl_evt & ~(wr_evt ? reg_wdata_i[1:0] : 2'b00)) | lvl_chg;
    end
  end

  // Read data, valid only in the cycle after the read strobe
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 16'h0000;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `REG_POWER_CTRL:  reg_rdata_o <= power_ctrl;
        `REG_SPLIT_CTRL:  reg_rdata_o <= {12'h000, split_ctrl};
        `REG_CHARGE_CTRL: reg_rdata_o <= {12'h000, charge_supply_present_o};
        `REG_FILTER_LEN:  reg_rdata_o <= filter_len;
        `REG_OC_STATUS:   reg_rdata_o <= {6'h00, oc_plug, oc_ss, oc_prim};
        `REG_CC_CFG:      reg_rdata_o <= cc_cfg;
        `REG_CC_STATUS:   reg_rdata_o <= {p2_level[2:0], flip[1], attached[1],
                                          port2_plug_supply_enable_o, 2'b00,
                                          p1_level[2:0], flip[0], attached[0],
                                          port1_plug_supply_enable_b_o,
                                          port1_plug_supply_enable_a_o, 1'b0};
        `REG_CC_EVENTS:   reg_rdata_o <= {14'h0000, lvl_evt};
        default:          reg_rdata_o <= 16'h0000;
      endcase
    end
    else
    begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule

// *** verif/port_power_partner.sv ***
// Purpose: Far-side model of the shared power pins: switch or fuse per port
// Assumes: Device drives only low; pin has an external pull-up path when on
// Notes:   A pin nobody holds wanders every cycle so a stale level never passes
module port_power_partner (
  // Clock
  input  logic       clk_i,
  // Device side of the pin
  input  logic [3:0] drv_i,
  input  logic [3:0] oe_i,
  input  logic [3:0] pullup_i,
  // Over-current command per port
  input  logic [3:0] fault_i,
  // Resolved pin level
  output logic [3:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] float_pat = 4'h5;

  // Undriven level changes each cycle
  always @(posedge clk_i)
    float_pat <= ~float_pat;

  // Switch flag output or opened fuse pulls the wire low
  always_comb
    for (int i = 0; i < 4; i++)
      pin_o[i] = oe_i[i] ? drv_i[i] : (pullup_i[i] ? !fault_i[i] : float_pat[i]);
endmodule

// *** verif/port_power_chk.sv ***
// Purpose: Port-level assertions for the port power manager
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module below
`include "port_power_defines.vh"
module port_power_chk (
  // Clock and reset
  input logic        clk_i,
  input logic        rst_n_i,
  // Register port
  input logic [3:0]  reg_addr_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [15:0] reg_rdata_o,
  // Power pins
  input logic [3:0]  port_power_sense_pin_o,
  input logic [3:0]  port_power_sense_pin_oe_o,
  input logic [3:0]  port_power_sense_pullup_o,
  input logic [3:0]  superspeed_power_sense_pin_oe_o,
  input logic [3:0]  superspeed_power_sense_pullup_o,
  // CC controls
  input logic [3:0]  cc_adv_code_o,
  input logic [1:0]  cc_rd_enable_o,
  input logic        port1_plug_supply_enable_a_o,
  input logic        port1_plug_supply_enable_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_drive_low: assert property ((port_power_sense_pin_oe_o & port_power_sense_pin_o) == 4'h0)
    else $error("driven power pin not low");
  chk_pullup_off: assert property ((port_power_sense_pin_oe_o & port_power_sense_pullup_o) == 4'h0)
    else $error("pull-up on while driving low");
  chk_open_drain: assert property ((port_power_sense_pin_oe_o ^ port_power_sense_pullup_o) == 4'hf)
    else $error("power pin neither driven nor pulled up");
  chk_ss_exclusive: assert property
    ((superspeed_power_sense_pin_oe_o & superspeed_power_sense_pullup_o) == 4'h0)
    else $error("superspeed pin driven with pull-up");
  chk_power_by_write: assert property ($changed(port_power_sense_pin_oe_o) |->
    $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == `REG_POWER_CTRL)
    else $error("power pin changed without power write");
  chk_vconn_one_pin: assert property
    (!(port1_plug_supply_enable_a_o && port1_plug_supply_enable_b_o))
    else $error("plug supply on both pins");
  chk_sink_no_adv: assert property ((cc_rd_enable_o[0] && $past(cc_rd_enable_o[0])) |->
    cc_adv_code_o[1:0] == 2'b11)
    else $error("sink role still advertising");
  chk_vconn_source: assert property ($rose(port1_plug_supply_enable_a_o) |->
    cc_adv_code_o[1:0] != 2'b11)
    else $error("plug supply enabled outside source role");
  chk_default_adv: assert property ($rose(rst_n_i) |-> ##[1:3] cc_adv_code_o == 4'h0)
    else $error("default advertisement not 3A");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
endmodule

bind port_power_manager port_power_chk chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .port_power_sense_pin_o(port_power_sense_pin_o),
  .port_power_sense_pin_oe_o(port_power_sense_pin_oe_o),
  .port_power_sense_pullup_o(port_power_sense_pullup_o),
  .superspeed_power_sense_pin_oe_o(superspeed_power_sense_pin_oe_o),
  .superspeed_power_sense_pullup_o(superspeed_power_sense_pullup_o),
  .cc_adv_code_o(cc_adv_code_o), .cc_rd_enable_o(cc_rd_enable_o),
  .port1_plug_supply_enable_a_o(port1_plug_supply_enable_a_o),
  .port1_plug_supply_enable_b_o(port1_plug_supply_enable_b_o));

// *** verif/test_port_power_manager.sv ***
// Purpose: Self-checking bench for the port power manager
// Assumes: 50 MHz clock, filter length shortened to 3 by register write
// Notes:   Register rows first, then pin, split and CC cases by hand
`include "port_power_defines.vh"
module test_port_power_manager;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  localparam row_t ROWS [14] = '{
    '{1'b0, `REG_POWER_CTRL, 16'h0, 16'h0000}, '{1'b0, `REG_SPLIT_CTRL, 16'h0, 16'h0000},
    '{1'b0, `REG_CHARGE_CTRL, 16'h0, 16'h0000}, '{1'b0, `REG_FILTER_LEN, 16'h0, 16'h0190},
    '{1'b0, `REG_OC_STATUS, 16'h0, 16'h0000}, '{1'b0, `REG_CC_CFG, 16'h0, 16'h0909},
    '{1'b0, `REG_CC_EVENTS, 16'h0, 16'h0000}, '{1'b0, 4'h8, 16'h0, 16'h0000},
    '{1'b1, `REG_CHARGE_CTRL, 16'hffff, 16'h000f}, '{1'b1, `REG_SPLIT_CTRL, 16'h0005, 16'h0005},
    '{1'b1, `REG_SPLIT_CTRL, 16'h0000, 16'h0000}, '{1'b1, `REG_FILTER_LEN, 16'h0003, 16'h0003},
    '{1'b1, 4'h9, 16'hffff, 16'h0000}, '{1'b1, `REG_CC_CFG, 16'hffff, 16'h7f7f}};
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [3:0]  pin, pin_drv, pin_oe, pin_pu, ss_pin, ss_drv, ss_oe, ss_pu, charge;
  logic [3:0]  fault = 4'h0;
  logic [3:0]  ss_fault = 4'h0;
  logic [11:0] level = 12'h0;
  logic [3:0]  ra = 4'h0;
  logic [3:0]  vlow = 4'h0;
  logic [3:0]  vbus = 4'h0;
  logic [3:0]  adv;
  logic [1:0]  rd_en;
  logic [5:0]  thr;
  logic        en_a, en_b, en_p2;
  logic [15:0] v;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  port_power_manager dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .port_power_sense_pin_i(pin), .port_power_sense_pin_o(pin_drv),
    .port_power_sense_pin_oe_o(pin_oe), .port_power_sense_pullup_o(pin_pu),
    .superspeed_power_sense_pin_i(ss_pin), .superspeed_power_sense_pin_o(ss_drv),
    .superspeed_power_sense_pin_oe_o(ss_oe), .superspeed_power_sense_pullup_o(ss_pu),
    .charge_supply_present_o(charge), .cc_level_i(level), .cc_ra_i(ra),
    .vconn_low_i(vlow), .bus_voltage_monitor_i(vbus), .cc_adv_code_o(adv),
    .cc_rd_enable_o(rd_en), .cc_threshold_o(thr), .port1_plug_supply_enable_a_o(en_a),
    .port1_plug_supply_enable_b_o(en_b), .port2_plug_supply_enable_o(en_p2));
  port_power_partner prim (.clk_i(clk_i), .drv_i(pin_drv), .oe_i(pin_oe), .pullup_i(pin_pu),
    .fault_i(fault), .pin_o(pin));
  port_power_partner supr (.clk_i(clk_i), .drv_i(ss_drv), .oe_i(ss_oe), .pullup_i(ss_pu),
    .fault_i(ss_fault), .pin_o(ss_pin));

  // Clock and hang guard
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Sustained or short low on the chosen pin set
  task automatic pulse(input logic ss, input logic [3:0] m, input int n);
    @(posedge clk_i);
    if (ss) ss_fault <= m; else fault <= m;
    repeat (n) @(posedge clk_i);
    ss_fault <= 4'h0;
    fault <= 4'h0;
    tick(10);
  endtask

  initial
  begin
    tick(4);
    rst_n_i <= 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr) wr_reg(ROWS[i].a, ROWS[i].d);
      rd_reg(ROWS[i].a, v);
      check("register row", v, ROWS[i].e);
    end
    check("charge indication", {12'h0, charge}, 16'h000f);
    wr_reg(`REG_POWER_CTRL, 16'h0003);
    tick(2);
    check("power pin oe", {pin_oe, pin_pu, ss_oe, ss_pu}, 16'hc300);
    pulse(1'b0, 4'h3, 3);
    rd_reg(`REG_OC_STATUS, v);
    check("glitch filtered", v, 16'h0000);
    pulse(1'b0, 4'hf, 20);
    rd_reg(`REG_OC_STATUS, v);
    check("over-current flags", v, 16'h0033);
    wr_reg(`REG_OC_STATUS, 16'h0033);
    rd_reg(`REG_OC_STATUS, v);
    check("flags cleared", v, 16'h0000);
    wr_reg(`REG_SPLIT_CTRL, 16'h0001);
    wr_reg(`REG_POWER_CTRL, 16'h0011);
    tick(2);
    check("split pins", {pin_oe, pin_pu, ss_oe, ss_pu}, 16'he101);
    pulse(1'b1, 4'h1, 20);
    rd_reg(`REG_OC_STATUS, v);
    check("split flag", v, 16'h0010);
    wr_reg(`REG_POWER_CTRL, 16'h0001);
    tick(2);
    check("split power off", {12'h0, ss_oe}, 16'h0001);
    wr_reg(`REG_CC_CFG, 16'h0939);
    @(posedge clk_i);
    ra <= 4'h1;
    tick(10);
    check("no supply before attach", {15'h0, en_a}, 16'h0000);
    check("threshold", {13'h0, thr[2:0]}, 16'h0003);
    @(posedge clk_i);
    level <= 12'h028;
    tick(10);
    check("supply pins", {14'h0, en_a, en_b}, 16'h0002);
    rd_reg(`REG_CC_STATUS, v);
    check("dfp status", v & 16'h001e, 16'h001a);
    @(posedge clk_i);
    vlow <= 4'h1;
    tick(15);
    check("supply shut off", {15'h0, en_a}, 16'h0000);
    rd_reg(`REG_OC_STATUS, v);
    check("supply flag", v & 16'h0300, 16'h0100);
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(`REG_CC_CFG, {8'h09, 5'h0, k[1:0], 1'b1});
      tick(3);
      check("advertisement", {14'h0, adv[1:0]}, {14'h0, k[1:0]});
    end
    wr_reg(`REG_CC_CFG, 16'h0900);
    @(posedge clk_i);
    level <= 12'h010;
    vlow <= 4'h0;
    tick(3);
    check("sink controls", {12'h0, adv[1:0], rd_en}, 16'h00d);
    @(posedge clk_i);
    vbus <= 4'h1;
    tick(10);
    rd_reg(`REG_CC_STATUS, v);
    check("sink attach", v & 16'h00e8, 16'h0048);
    wr_reg(`REG_CC_EVENTS, 16'h0003);
    @(posedge clk_i);
    level <= 12'h020;
    tick(10);
    rd_reg(`REG_CC_EVENTS, v);
    check("level change", v & 16'h0001, 16'h0001);
    @(posedge clk_i);
    vbus <= 4'h2;
    tick(10);
    rd_reg(`REG_CC_STATUS, v);
    check("sink detach", v & 16'h0008, 16'h0000);
    stop_test();
  end
endmodule
